//--- sbm_pkg.sv
// Constants, register map and types for the slot breakdown metrics unit
// Summary of operation
// [R01] Bytes 0..3 of the metrics register hold the four level-1 fractions of 255.
// [R02] Capability register bit 15 tells software the metrics facility exists.
// [R03] Metrics accumulate only while control bits 48 and 35 are both set.
// [R04] Writing one to bit 48 of the status-set register sets the overflow flag.
// [R05] Writing one to bit 48 of the status-clear register clears that flag.
// [R06] A metrics overflow sets status bit 48 and raises the monitor interrupt.
// [R07] Every metrics value is derived from the slot count in fixed counter 3.
// [R08] Software restarts counter 3 and metrics when status bit 35 or 48 is set.
// [R09] Software starts counter 3 and metrics from zero and clears them often.
// [R10] Software saves and restores both disabled, toggling bits 48 and 35 at once.
// [R11] On restore software writes counter 3 before the metrics register.
// [R12] The extended variant fills bytes 4..7 with four level-2 fractions of 255.
// [R13] Each level-2 fraction is a part of its level-1 parent and never exceeds it.
// [R14] Event codes below 0x90 may use counters 0-3 only; higher ones are free.
// [R15] Codes 3C and 2E use 0-7; Dx and three A3 encodings 0-3; 02CD 04A4 08A4 CE 0.
// [R16] An event encoding is unit mask in the high byte, event code in the low byte.
// [R17] All metrics fields change together from one consistent snapshot.
package sbm_pkg;
  // Byte offsets on the register bus
  localparam logic [7:0] OFF_CAP = 8'h00;
  localparam logic [7:0] OFF_CTRL_LO = 8'h04;
  localparam logic [7:0] OFF_CTRL_HI = 8'h08;
  localparam logic [7:0] OFF_STAT_LO = 8'h0C;
  localparam logic [7:0] OFF_STAT_HI = 8'h10;
  localparam logic [7:0] OFF_SSET_HI = 8'h14;
  localparam logic [7:0] OFF_SCLR_HI = 8'h18;
  localparam logic [7:0] OFF_CTR3_LO = 8'h1C;
  localparam logic [7:0] OFF_CTR3_HI = 8'h20;
  localparam logic [7:0] OFF_MET_LO = 8'h24;
  localparam logic [7:0] OFF_MET_HI = 8'h28;
  localparam logic [7:0] OFF_IRQ_ST = 8'h2C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFF_EVQ = 8'h34;
  // Bit positions
  localparam int BIT_CAP_AVAIL = 15;
  localparam int BIT_CAP_EXT = 0;
  localparam int BIT_CTR3_EN = 35;
  localparam int BIT_MET_EN = 48;
  // Same bits seen in the upper 32-bit word, then interrupt status and mask bits
  localparam int HBIT_CTR3 = 3;
  localparam int HBIT_MET = 16;
  localparam int IRQ_CTR3 = 0;
  localparam int IRQ_MET = 1;
  // Reset values
  localparam logic [63:0] CTRL_RST = 64'h0;
  localparam logic [63:0] METRICS_RST = 64'h0;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;
  // Divider timing: one bit per cycle, eight quotient bits per field
  localparam logic [2:0] DIV_TOP_BIT = 3'h7;
  localparam logic [2:0] LAST_FIELD = 3'h7;
  localparam logic [2:0] LAST_L1_FIELD = 3'h3;
  // Event restriction codes and counter masks, then bus response codes
  localparam logic [7:0] EV_FREE_FROM = 8'h90;
  localparam logic [7:0] EV_CLK = 8'h3C;
  localparam logic [7:0] EV_LLC = 8'h2E;
  localparam logic [3:0] EV_MEM_NIB = 4'hD;
  localparam logic [7:0] EV_CYC_ACT = 8'hA3;
  localparam logic [7:0] EV_AMX = 8'hCE;
  localparam logic [15:0] EV_CYC_A = 16'h01A3;
  localparam logic [15:0] EV_CYC_B = 16'h02A3;
  localparam logic [15:0] EV_CYC_C = 16'h08A3;
  localparam logic [15:0] EV_ST_SAMPLE = 16'h02CD;
  localparam logic [15:0] EV_BAD_SPEC = 16'h04A4;
  localparam logic [15:0] EV_BR_MISP = 16'h08A4;
  localparam logic [7:0] CNT_ALL = 8'hFF;
  localparam logic [7:0] CNT_LOW4 = 8'h0F;
  localparam logic [7:0] CNT_ONLY0 = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SBM_IDLE = 2'b00,
    SBM_LOAD = 2'b01,
    SBM_DIV = 2'b10
  } sbm_div_state_t;
endpackage : sbm_pkg

//--- sbm_restrict_decode.sv
// Event encoding to allowed general-purpose counter mask
`timescale 1ns/100ps
module sbm_restrict_decode (
  input wire logic [15:0] evEncoding,
  output logic [7:0] allowedMask
);
  import sbm_pkg::*;
  logic [7:0] evCode;

  // [R16] Unit mask high byte
  assign evCode = evEncoding[7:0];

  always_comb begin
    // [R14] Code based default
    allowedMask = (evCode < EV_FREE_FROM) ? CNT_LOW4 : CNT_ALL;
    // [R15] Listed exceptions, narrowest last
    if (evCode == EV_CLK || evCode == EV_LLC) begin
      allowedMask = CNT_ALL;
    end else if (evCode[7:4] == EV_MEM_NIB) begin
      allowedMask = CNT_LOW4;
    end
    if (evEncoding == EV_CYC_A || evEncoding == EV_CYC_B ||
        evEncoding == EV_CYC_C) begin
      allowedMask = CNT_LOW4;
    end
    if (evEncoding == EV_ST_SAMPLE || evEncoding == EV_BAD_SPEC ||
        evEncoding == EV_BR_MISP || evCode == EV_AMX) begin
      allowedMask = CNT_ONLY0;
    end
  end
endmodule : sbm_restrict_decode

//--- sbm_metrics_unit.sv
// Slot breakdown metrics unit with AXI4-Lite register access
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
module sbm_metrics_unit #(
  parameter int CW = 48,
  parameter int SW = 4,
  parameter bit EXTENDED = 1'b1
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [SW-1:0] slotCount,
  input wire logic [SW-1:0] retiringSlots,
  input wire logic [SW-1:0] badSpecSlots,
  input wire logic [SW-1:0] frontendSlots,
  input wire logic [SW-1:0] backendSlots,
  input wire logic [SW-1:0] heavyOpsSlots,
  input wire logic [SW-1:0] mispredictSlots,
  input wire logic [SW-1:0] fetchLatSlots,
  input wire logic [SW-1:0] memBoundSlots,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic monitorInterrupt
);
  import sbm_pkg::*;

  typedef struct packed {
    sbm_div_state_t divState;
    logic [2:0] divIdx;
    logic [2:0] bitIdx;
    logic [CW+7:0] rem;
    logic [CW-1:0] den;
    logic [7:0][CW-1:0] snap;
    logic [63:0] shadow;
    logic [7:0][CW-1:0] acc;
    logic [CW-1:0] ctr3;
    logic [63:0] ctrl;
    logic [63:0] metrics;
    logic ovfCtr3;
    logic ovfMetrics;
    logic [1:0] irqSt;
    logic [1:0] irqMask;
    logic [15:0] evEnc;
    logic [7:0] evMask;
    logic awHeld;
    logic [7:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sbm_state_t;

  sbm_state_t r;
  sbm_state_t next_r;
  logic [7:0] decMask;
  logic [7:0][SW-1:0] laneIn;
  logic active;
  logic doWrite;
  logic doRead;
  logic metWr;
  logic commit;
  logic metCause;
  logic [CW+7:0] denSh;
  logic [63:0] capWord;

  function automatic logic [31:0] applyStrobes(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction : applyStrobes

  sbm_restrict_decode u_restrict (
    .evEncoding(r.evEnc),
    .allowedMask(decMask)
  );

  // [R13] Level-2 lanes clamped to their parent lane
  always_comb begin
    laneIn[0] = retiringSlots;
    laneIn[1] = badSpecSlots;
    laneIn[2] = frontendSlots;
    laneIn[3] = backendSlots;
    laneIn[4] = (heavyOpsSlots > retiringSlots) ? retiringSlots : heavyOpsSlots;
    laneIn[5] = (mispredictSlots > badSpecSlots) ? badSpecSlots
                                                 : mispredictSlots;
    laneIn[6] = (fetchLatSlots > frontendSlots) ? frontendSlots : fetchLatSlots;
    laneIn[7] = (memBoundSlots > backendSlots) ? backendSlots : memBoundSlots;
  end

  // [R02] Capability word advertises the facility
  always_comb begin
    capWord = 64'h0;
    capWord[BIT_CAP_AVAIL] = 1'b1;
    capWord[BIT_CAP_EXT] = EXTENDED;
  end

  // [R03] Both enables needed
  assign active = r.ctrl[BIT_MET_EN] && r.ctrl[BIT_CTR3_EN];
  assign doWrite = r.awHeld && r.wHeld && !r.bvalid;
  assign doRead = s_axi_arvalid && !r.rvalid;
  assign metWr = doWrite &&
                 (r.awAddr == OFF_MET_LO || r.awAddr == OFF_MET_HI);
  assign denSh = (CW+8)'(r.den) << r.bitIdx;
  assign commit = r.divState == SBM_DIV && r.bitIdx == 3'h0 &&
                  r.divIdx == LAST_FIELD && !metWr;

  assign s_axi_awready = !r.awHeld && !r.bvalid;
  assign s_axi_wready = !r.wHeld && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  // High while any unmasked sticky bit stands
  assign monitorInterrupt = |(r.irqSt & r.irqMask);

  always_comb begin
    logic [CW:0] sum;
    logic [CW:0] cnt;
    logic metOvfEv;
    logic ctrOvfEv;
    logic qBit;
    logic [1:0] irqEv;
    logic [31:0] wv;
    logic [7:0] fld;
    sum = '0;
    cnt = '0;
    metOvfEv = 1'b0;
    ctrOvfEv = 1'b0;
    qBit = 1'b0;
    irqEv = 2'h0;
    wv = 32'h0;
    fld = 8'h0;
    next_r = r;

    // [R07] Counter 3 accumulates the slot count
    if (r.ctrl[BIT_CTR3_EN]) begin
      cnt = {1'b0, r.ctr3} + (CW+1)'(slotCount);
      next_r.ctr3 = cnt[CW-1:0];
      ctrOvfEv = cnt[CW];
    end
    // [R03] Lane accumulation gated by both enables
    if (active) begin
      for (int k = 0; k < 8; k++) begin
        sum = {1'b0, r.acc[k]} + (CW+1)'(laneIn[k]);
        next_r.acc[k] = sum[CW-1:0];
        metOvfEv = metOvfEv | sum[CW];
      end
    end

    // [R17] Snapshot then divide field by field
    case (r.divState)
      SBM_IDLE: begin
        if (active) begin
          next_r.snap = r.acc;
          next_r.den = r.ctr3;
          next_r.divIdx = 3'h0;
          next_r.divState = SBM_LOAD;
        end
      end
      SBM_LOAD: begin
        next_r.rem = {r.snap[r.divIdx], 8'h0} - (CW+8)'(r.snap[r.divIdx]);
        next_r.bitIdx = DIV_TOP_BIT;
        next_r.divState = SBM_DIV;
      end
      SBM_DIV: begin
        // [R01] Fraction of 255 by long division
        qBit = (r.den != '0) && (r.rem >= denSh);
        if (qBit) begin
          next_r.rem = r.rem - denSh;
        end
        next_r.shadow[{r.divIdx, r.bitIdx}] = qBit;
        if (r.bitIdx != 3'h0) begin
          next_r.bitIdx = r.bitIdx - 3'h1;
        end else if (r.divIdx != LAST_FIELD) begin
          next_r.divIdx = r.divIdx + 3'h1;
          next_r.divState = SBM_LOAD;
        end else begin
          // [R12] Upper half only on the extended variant
          next_r.metrics = next_r.shadow;
          if (!EXTENDED) begin
            next_r.metrics[63:32] = 32'h0;
          end
          next_r.divState = SBM_IDLE;
        end
      end
      default: next_r.divState = SBM_IDLE;
    endcase

    next_r.evMask = decMask;

    // Write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_r.awHeld = 1'b1;
      next_r.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_r.wHeld = 1'b1;
      next_r.wData = s_axi_wdata;
      next_r.wStrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    if (doWrite) begin
      next_r.awHeld = 1'b0;
      next_r.wHeld = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (r.awAddr == OFF_CTRL_LO) begin
        next_r.ctrl[31:0] = applyStrobes(r.ctrl[31:0], r.wData, r.wStrb);
      end else if (r.awAddr == OFF_CTRL_HI) begin
        next_r.ctrl[63:32] = applyStrobes(r.ctrl[63:32], r.wData, r.wStrb);
      end else if (r.awAddr == OFF_CTR3_LO) begin
        wv = applyStrobes(r.ctr3[31:0], r.wData, r.wStrb);
        next_r.ctr3[31:0] = wv;
      end else if (r.awAddr == OFF_CTR3_HI) begin
        wv = applyStrobes(32'(r.ctr3[CW-1:32]), r.wData, r.wStrb);
        next_r.ctr3[CW-1:32] = wv[CW-33:0];
      end else if (metWr) begin
        // Restore rebuilds lane totals from counter 3
        // A commit in this cycle must not leak into the other half
        next_r.metrics = r.metrics;
        if (r.awAddr == OFF_MET_LO) begin
          next_r.metrics[31:0] = applyStrobes(r.metrics[31:0], r.wData,
                                              r.wStrb);
        end else begin
          next_r.metrics[63:32] = applyStrobes(r.metrics[63:32], r.wData,
                                               r.wStrb);
        end
        // [R11] Uses the counter 3 value already present
        for (int k = 0; k < 8; k++) begin
          fld = next_r.metrics[k*8 +: 8];
          next_r.acc[k] = CW'(((CW+8)'(r.ctr3) * (CW+8)'(fld)) >> 8);
        end
        // A pass in flight would overwrite the restored value
        next_r.divState = SBM_IDLE;
        metOvfEv = 1'b0;
      end else if (r.awAddr == OFF_IRQ_MASK) begin
        next_r.irqMask = r.wStrb[0] ? r.wData[1:0] : r.irqMask;
      end else if (r.awAddr == OFF_EVQ) begin
        wv = applyStrobes({16'h0, r.evEnc}, r.wData, r.wStrb);
        next_r.evEnc = wv[15:0];
      end else if (r.awAddr == OFF_SSET_HI || r.awAddr == OFF_SCLR_HI ||
                   r.awAddr == OFF_CAP || r.awAddr == OFF_STAT_LO ||
                   r.awAddr == OFF_STAT_HI || r.awAddr == OFF_IRQ_ST) begin
        next_r.bresp = RESP_OKAY;
      end else begin
        next_r.bresp = RESP_SLVERR;
      end
    end

    // [R05] Clear first so that a set in the same cycle wins
    if (doWrite && r.awAddr == OFF_SCLR_HI) begin
      if (r.wData[HBIT_MET]) begin
        next_r.ovfMetrics = 1'b0;
      end
      if (r.wData[HBIT_CTR3]) begin
        next_r.ovfCtr3 = 1'b0;
      end
    end
    // [R04] Software set of the overflow flag
    if (doWrite && r.awAddr == OFF_SSET_HI) begin
      if (r.wData[HBIT_MET]) begin
        next_r.ovfMetrics = 1'b1;
      end
      if (r.wData[HBIT_CTR3]) begin
        next_r.ovfCtr3 = 1'b1;
      end
    end
    // [R06] Hardware overflow sets the flag
    if (metOvfEv) begin
      next_r.ovfMetrics = 1'b1;
    end
    if (ctrOvfEv) begin
      next_r.ovfCtr3 = 1'b1;
    end

    // [R06] Rising status bits raise sticky interrupt bits
    irqEv[IRQ_MET] = next_r.ovfMetrics && !r.ovfMetrics;
    irqEv[IRQ_CTR3] = next_r.ovfCtr3 && !r.ovfCtr3;

    // Read channel; a status read clears it but a new event survives
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    next_r.irqSt = r.irqSt | irqEv;
    if (doRead) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = 32'h0;
      if (s_axi_araddr == OFF_CAP) begin
        next_r.rdata = capWord[31:0];
      end else if (s_axi_araddr == OFF_CTRL_LO) begin
        next_r.rdata = r.ctrl[31:0];
      end else if (s_axi_araddr == OFF_CTRL_HI) begin
        next_r.rdata = r.ctrl[63:32];
      end else if (s_axi_araddr == OFF_STAT_HI) begin
        next_r.rdata[HBIT_MET] = r.ovfMetrics;
        next_r.rdata[HBIT_CTR3] = r.ovfCtr3;
      end else if (s_axi_araddr == OFF_CTR3_LO) begin
        next_r.rdata = r.ctr3[31:0];
      end else if (s_axi_araddr == OFF_CTR3_HI) begin
        next_r.rdata = 32'(r.ctr3[CW-1:32]);
      end else if (s_axi_araddr == OFF_MET_LO) begin
        next_r.rdata = r.metrics[31:0];
      end else if (s_axi_araddr == OFF_MET_HI) begin
        next_r.rdata = r.metrics[63:32];
      end else if (s_axi_araddr == OFF_IRQ_ST) begin
        next_r.rdata = {30'h0, r.irqSt};
        next_r.irqSt = irqEv;
      end else if (s_axi_araddr == OFF_IRQ_MASK) begin
        next_r.rdata = {30'h0, r.irqMask};
      end else if (s_axi_araddr == OFF_EVQ) begin
        next_r.rdata = {8'h0, r.evMask, r.evEnc};
      end else if (s_axi_araddr == OFF_STAT_LO ||
                   s_axi_araddr == OFF_SSET_HI ||
                   s_axi_araddr == OFF_SCLR_HI) begin
        next_r.rdata = 32'h0;
      end else begin
        next_r.rresp = RESP_SLVERR;
      end
    end
  end

  assign metCause = doWrite && r.awAddr == OFF_SSET_HI && r.wData[HBIT_MET];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      r.divState <= SBM_IDLE;
      r.ctrl <= CTRL_RST;
      r.metrics <= METRICS_RST;
      r.irqMask <= IRQ_MASK_RST;
    end else begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  property p_gate;
    !active && !metWr |=> $stable(r.acc);
  endproperty
  a_gate: assert property (p_gate) else $error("lanes moved while disabled"); // [R03]

  property p_set;
    metCause |=> r.ovfMetrics;
  endproperty
  a_set: assert property (p_set) else $error("status set missed"); // [R04]

  property p_clr;
    doWrite && r.awAddr == OFF_SCLR_HI && r.wData[HBIT_MET] && !active
      |=> !r.ovfMetrics;
  endproperty
  a_clr: assert property (p_clr) else $error("status clear missed"); // [R05]

  property p_cause;
    $rose(r.ovfMetrics) |-> $past(metCause) || $past(active);
  endproperty
  a_cause: assert property (p_cause) else $error("flag without cause"); // [R06]

  property p_irq;
    $rose(r.ovfMetrics) && r.irqMask[IRQ_MET] |-> monitorInterrupt;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // [R06]

  property p_sub;
    $changed(r.metrics) && !$past(metWr) |->
      r.metrics[39:32] <= r.metrics[7:0] &&
      r.metrics[47:40] <= r.metrics[15:8] &&
      r.metrics[55:48] <= r.metrics[23:16] &&
      r.metrics[63:56] <= r.metrics[31:24];
  endproperty
  a_sub: assert property (p_sub) else $error("level-2 above parent"); // [R13]

  property p_whole;
    $changed(r.metrics) |-> $past(commit) || $past(metWr);
  endproperty
  a_whole: assert property (p_whole) else $error("partial update"); // [R17]

  property p_zero;
    commit && r.den == '0 |=> r.metrics == 64'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("nonzero with no slots"); // [R07]

  property p_amx;
    r.evEnc[7:0] == EV_AMX ##1 $stable(r.evEnc) |-> r.evMask == CNT_ONLY0;
  endproperty
  a_amx: assert property (p_amx) else $error("counter 0 limit lost"); // [R15]

  property p_low;
    r.evEnc == 16'h0020 ##1 $stable(r.evEnc) |-> r.evMask == CNT_LOW4;
  endproperty
  a_low: assert property (p_low) else $error("low code not limited"); // [R14]
endmodule : sbm_metrics_unit

//--- tb.sv
// Self-checking testbench for the slot breakdown metrics unit
`timescale 1ns/100ps
module tb;
  import sbm_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] slotCount = 4'h0;
  logic [3:0] lane [8];
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic monitorInterrupt;
  integer n_mismatch = 0;
  integer compares = 0;
  integer cycles = 0;

  initial foreach (lane[i]) lane[i] = 4'h0;
  initial forever #25 sys_clk = ~sys_clk;

  sbm_metrics_unit u_dut (
    .sys_clk(sys_clk), .rst(rst), .slotCount(slotCount),
    .retiringSlots(lane[0]), .badSpecSlots(lane[1]),
    .frontendSlots(lane[2]), .backendSlots(lane[3]),
    .heavyOpsSlots(lane[4]), .mispredictSlots(lane[5]),
    .fetchLatSlots(lane[6]), .memBoundSlots(lane[7]),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .monitorInterrupt(monitorInterrupt)
  );

  task check(input string name, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task print_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // Handshakes are sampled at the falling edge, where the slave's outputs
  // have settled and equal what the next rising edge will see
  task axi_write(input logic [7:0] a, input logic [31:0] d,
                 output logic [1:0] resp);
    logic done;
    logic awGo;
    logic wGo;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge sys_clk);
      awGo = s_axi_awvalid && s_axi_awready;
      wGo = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge sys_clk);
      if (awGo) s_axi_awvalid <= 1'b0;
      if (wGo) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
  endtask : axi_write

  task axi_read(input logic [7:0] a, output logic [31:0] d,
                output logic [1:0] resp);
    logic done;
    logic arGo;
    done = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge sys_clk);
      arGo = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      d = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge sys_clk);
      if (arGo) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
  endtask : axi_read

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    check("write response", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wr

  task rd_check(input string name, input logic [7:0] a,
                input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(name, d, exp);
    check("read response", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask : rd_check

  task test_ident_unmapped;
    logic [31:0] d;
    logic [1:0] r;
    rd_check("capability", OFF_CAP, 32'h00008001);
    axi_read(8'h3C, d, r);
    check("unmapped read resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    check("unmapped read data", d, 32'h0);
    axi_write(8'h3C, 32'hFFFFFFFF, r);
    check("unmapped write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : test_ident_unmapped

  task test_status_irq;
    wr(OFF_SSET_HI, 32'h00010000);
    rd_check("status after set", OFF_STAT_HI, 32'h00010000);
    check("irq while masked", {31'h0, monitorInterrupt}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h00000002);
    repeat (2) @(posedge sys_clk);
    check("irq unmasked", {31'h0, monitorInterrupt}, 32'h1);
    rd_check("irq status", OFF_IRQ_ST, 32'h00000002);
    repeat (2) @(posedge sys_clk);
    check("irq after read", {31'h0, monitorInterrupt}, 32'h0);
    rd_check("irq status cleared", OFF_IRQ_ST, 32'h0);
    wr(OFF_SCLR_HI, 32'h00010000);
    rd_check("status after clear", OFF_STAT_HI, 32'h0);
    wr(OFF_SSET_HI, 32'h00010000);
    check("irq on unmasked set", {31'h0, monitorInterrupt}, 32'h1);
    rd_check("irq status again", OFF_IRQ_ST, 32'h00000002);
    wr(OFF_SCLR_HI, 32'h00010000);
    rd_check("status cleared again", OFF_STAT_HI, 32'h0);
  endtask : test_status_irq

  task test_event_query;
    logic [15:0] enc [12];
    logic [7:0] msk [12];
    enc = '{16'h003C, 16'h012E, 16'h01D0, 16'h01A3, 16'h02A3, 16'h08A3,
            16'h02CD, 16'h04A4, 16'h08A4, 16'h01CE, 16'h0020, 16'h04A3};
    msk = '{8'hFF, 8'hFF, 8'h0F, 8'h0F, 8'h0F, 8'h0F,
            8'h01, 8'h01, 8'h01, 8'h01, 8'h0F, 8'hFF};
    foreach (enc[i]) begin
      wr(OFF_EVQ, {16'h0, enc[i]});
      rd_check("event mask", OFF_EVQ, {8'h0, msk[i], enc[i]});
    end
  endtask : test_event_query

  task test_metrics;
    @(posedge sys_clk);
    slotCount <= 4'h4;
    lane <= '{4'h2, 4'h1, 4'h1, 4'h0, 4'h1, 4'h3, 4'h0, 4'h2};
    wr(OFF_CTR3_LO, 32'h0);
    wr(OFF_MET_LO, 32'h0);
    wr(OFF_MET_HI, 32'h0);
    wr(OFF_CTRL_HI, 32'h00010000);
    repeat (100) @(posedge sys_clk);
    rd_check("metrics without ctr3", OFF_MET_LO, 32'h0);
    rd_check("ctr3 disabled", OFF_CTR3_LO, 32'h0);
    wr(OFF_CTRL_HI, 32'h00010008);
    repeat (250) @(posedge sys_clk);
    wr(OFF_CTRL_HI, 32'h0);
    repeat (100) @(posedge sys_clk);
    // Fractions are lane*255/4 rounded down for every snapshot length
    rd_check("level1 fields", OFF_MET_LO, 32'h003F3F7F);
    // Mispredict and memory lanes clamp to their parents
    rd_check("level2 fields", OFF_MET_HI, 32'h00003F3F);
  endtask : test_metrics

  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    test_ident_unmapped();
    test_status_irq();
    test_event_query();
    test_metrics();
    print_verdict();
  end
endmodule : tb
